// ---- common/loop_ctrl_pkg.sv ----
// Function
// - Free-run output comes from system clock only
// - Pre-locked, pre-locked2, lost-phase track reference transiently
// - Locked mode follows reference phase and frequency
// - First two seconds use starting bandwidth, damping
// - Acquisition stage uses acquisition bandwidth, damping
// - Locked stage uses locked bandwidth, damping
// - Stage selection is automatic, no software
// - Locked bandwidth codes above 10101 are reserved
// - Disqualified reference with none qualified changes mode
// - Lock indicator edges move into/out of locked
// - Switch event on disqualify with another qualified, revertive or forced change
// - Oscillator mode is a steered phase accumulator
// - Oscillator mode chosen by mode configuration register
// - Offset word is 40-bit signed two's complement
// - Word spans 92 ppm at fixed step
// - Host scales step by applied offset
// - Phase moves by frequency change times duration
// - Host servo limits bandwidth and phase slope
// - Host prefers snap alignment for large steps
// - Five-bit mode field encodes automatic and forced modes
// - Status shows mode; change flag, masked interrupt
// - Holdover uses stored locked frequency, no reference
package loop_ctrl_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int START_TIME_S = 2;
    localparam int START_CYCLES = START_TIME_S * CLK_HZ;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 4;
    localparam int FREQ_W = 40;
    localparam int ACC_W = 48;
    // Device register indices on the link
    localparam logic [3:0] REG_MODE_CFG = 4'h0;
    localparam logic [3:0] REG_MODE_STS = 4'h1;
    localparam logic [3:0] REG_EVENT = 4'h2;
    localparam logic [3:0] REG_MASK = 4'h3;
    localparam logic [3:0] REG_START = 4'h4;
    localparam logic [3:0] REG_ACQ = 4'h5;
    localparam logic [3:0] REG_LOCKED = 4'h6;
    localparam logic [3:0] REG_FREQ_LO = 4'h7;
    localparam logic [3:0] REG_FREQ_HI = 4'h8;
    // Code registers hold damping in [7:5], bandwidth in [4:0]
    localparam int BW_LSB = 0;
    localparam int DAMP_LSB = 5;
    localparam logic [4:0] BW_MAX = 5'h15;
    localparam logic [7:0] START_RST = 8'h6F;
    localparam logic [7:0] ACQ_RST = 8'h6F;
    localparam logic [7:0] LOCKED_RST = 8'h69;
    localparam logic [4:0] MODE_CFG_RST = 5'h00;
    // Mode codes
    localparam logic [4:0] MODE_AUTO = 5'h00;
    localparam logic [4:0] MODE_FREE = 5'h01;
    localparam logic [4:0] MODE_HOLD = 5'h02;
    localparam logic [4:0] MODE_LOCK = 5'h04;
    localparam logic [4:0] MODE_PRE2 = 5'h05;
    localparam logic [4:0] MODE_PRE = 5'h06;
    localparam logic [4:0] MODE_LOST = 5'h07;
    localparam logic [4:0] MODE_DCO = 5'h0A;
    // Host Wishbone byte addresses
    localparam logic [7:0] HOST_CTRL = 8'h00;
    localparam logic [7:0] HOST_WDATA = 8'h04;
    localparam logic [7:0] HOST_RDATA = 8'h08;
    localparam logic [7:0] HOST_STAT = 8'h0C;
    localparam int CTRL_WE_BIT = 8;

    typedef enum logic [2:0] {
        ST_FREE = 3'b000,
        ST_PRE = 3'b001,
        ST_PRE2 = 3'b010,
        ST_LOCK = 3'b011,
        ST_LOST = 3'b100,
        ST_HOLD = 3'b101,
        ST_DCO = 3'b110
    } loop_state_t;

    typedef enum logic [1:0] {
        STG_START = 2'b00,
        STG_ACQ = 2'b01,
        STG_LOCKED = 2'b10
    } stage_t;
endpackage : loop_ctrl_pkg

// ---- common/loop_link.sv ----
`timescale 1ns/100ps
interface loop_link;
    import loop_ctrl_pkg::*;
    logic req;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic ack;
    logic [DATA_W-1:0] rdata;
    logic irq;

    modport device (
        input req,
        input we,
        input addr,
        input wdata,
        output ack,
        output rdata,
        output irq
    );

    modport host (
        output req,
        output we,
        output addr,
        output wdata,
        input ack,
        input rdata,
        input irq
    );
endinterface : loop_link

// ---- hw/loop_ctrl.sv ----
// The Wishbone slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
module loop_ctrl #(
    parameter int START_CNT = loop_ctrl_pkg::START_CYCLES,
    parameter logic [47:0] NOMINAL_STEP = 48'h1000_0000_0000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register link from the host
    loop_link.device lnk,
    // Reference selector status
    input wire logic ref_selected,
    input wire logic ref_disqualified,
    input wire logic other_qualified,
    input wire logic revertive_pick,
    input wire logic forced_change,
    input wire logic loop_lock_indicator,
    input wire logic [loop_ctrl_pkg::FREQ_W-1:0] ref_freq_offset,
    // Loop controls out
    output logic [2:0] loop_state,
    output logic [1:0] loop_stage,
    output logic [4:0] active_bandwidth,
    output logic [2:0] active_damping,
    output logic switch_event,
    output logic [loop_ctrl_pkg::ACC_W-1:0] dco_phase
);
    import loop_ctrl_pkg::*;
    if (START_CNT < 1 || START_CNT >= (1 << 28)) begin : g_start_cnt_check
        $error("START_CNT out of range");
    end

    typedef struct packed {
        loop_state_t st;
        stage_t stg;
        logic [4:0] cfg;
        logic chg;
        logic mask;
        logic [7:0] start_c;
        logic [7:0] acq_c;
        logic [7:0] lck_c;
        logic [31:0] flo;
        logic [FREQ_W-1:0] freq;
        logic [FREQ_W-1:0] hold;
        logic [27:0] cnt;
        logic lock_q;
        logic [ACC_W-1:0] acc;
        logic ack;
        logic [DATA_W-1:0] rdata;
        logic irq;
        logic [4:0] bw;
        logic [2:0] damp;
        logic sw;
    } dev_t;

    dev_t s_r;
    dev_t s_nxt;

    function automatic logic [4:0] state_code(input loop_state_t st);
        case (st)
            ST_FREE: state_code = MODE_FREE;
            ST_PRE: state_code = MODE_PRE;
            ST_PRE2: state_code = MODE_PRE2;
            ST_LOCK: state_code = MODE_LOCK;
            ST_LOST: state_code = MODE_LOST;
            ST_HOLD: state_code = MODE_HOLD;
            default: state_code = MODE_DCO;
        endcase
    endfunction : state_code

    function automatic logic valid_cfg(input logic [4:0] c);
        valid_cfg = c inside {MODE_AUTO, MODE_FREE, MODE_HOLD, MODE_LOCK, MODE_PRE2, MODE_PRE,
            MODE_LOST, MODE_DCO};
    endfunction : valid_cfg

    function automatic logic [7:0] clamp_code(input logic [7:0] c);
        clamp_code = c;
        if (c[BW_LSB +: 5] > BW_MAX) begin
            clamp_code[BW_LSB +: 5] = BW_MAX;
        end
    endfunction : clamp_code

    logic lose_all;
    logic switched;
    logic lock_rise;
    logic lock_fall;
    logic [FREQ_W-1:0] step_off;

    always_comb begin
        s_nxt = s_r;
        lose_all = ref_disqualified && !other_qualified;
        switched = (ref_disqualified && other_qualified) || revertive_pick || forced_change;
        lock_rise = loop_lock_indicator && !s_r.lock_q;
        lock_fall = !loop_lock_indicator && s_r.lock_q;
        s_nxt.lock_q = loop_lock_indicator;
        s_nxt.sw = switched;
        s_nxt.ack = 1'b0;

        // Register access; ack drops the cycle after it is given
        if (lnk.req && !s_r.ack) begin
            s_nxt.ack = 1'b1;
            s_nxt.rdata = '0;
            if (lnk.addr == REG_MODE_CFG) begin
                s_nxt.rdata[4:0] = s_r.cfg;
                if (lnk.we && valid_cfg(lnk.wdata[4:0])) begin
                    s_nxt.cfg = lnk.wdata[4:0];
                end
            end else if (lnk.addr == REG_MODE_STS) begin
                s_nxt.rdata[4:0] = state_code(s_r.st);
            end else if (lnk.addr == REG_EVENT) begin
                s_nxt.rdata[0] = s_r.chg;
                if (lnk.we && lnk.wdata[0]) begin
                    s_nxt.chg = 1'b0;
                end
            end else if (lnk.addr == REG_MASK) begin
                s_nxt.rdata[0] = s_r.mask;
                if (lnk.we) begin
                    s_nxt.mask = lnk.wdata[0];
                end
            end else if (lnk.addr == REG_START) begin
                s_nxt.rdata[7:0] = s_r.start_c;
                if (lnk.we) begin
                    s_nxt.start_c = clamp_code(lnk.wdata[7:0]);
                end
            end else if (lnk.addr == REG_ACQ) begin
                s_nxt.rdata[7:0] = s_r.acq_c;
                if (lnk.we) begin
                    s_nxt.acq_c = clamp_code(lnk.wdata[7:0]);
                end
            end else if (lnk.addr == REG_LOCKED) begin
                s_nxt.rdata[7:0] = s_r.lck_c;
                if (lnk.we) begin
                    s_nxt.lck_c = clamp_code(lnk.wdata[7:0]);
                end
            end else if (lnk.addr == REG_FREQ_LO) begin
                s_nxt.rdata = s_r.freq[31:0];
                if (lnk.we) begin
                    s_nxt.flo = lnk.wdata;
                end
            end else if (lnk.addr == REG_FREQ_HI) begin
                s_nxt.rdata[7:0] = s_r.freq[39:32];
                // Both halves land together so the oscillator never sees a torn word
                if (lnk.we) begin
                    s_nxt.freq = {lnk.wdata[7:0], s_r.flo};
                end
            end
        end

        // Mode machine
        if (s_r.cfg == MODE_AUTO) begin
            case (s_r.st)
                ST_FREE: begin
                    if (ref_selected) begin
                        s_nxt.st = ST_PRE;
                    end
                end
                ST_PRE: begin
                    if (lose_all) begin
                        s_nxt.st = ST_FREE;
                    end else if (switched) begin
                        s_nxt.st = ST_PRE;
                    end else if (lock_rise) begin
                        s_nxt.st = ST_LOCK;
                    end
                end
                ST_LOCK: begin
                    if (lose_all) begin
                        s_nxt.st = ST_HOLD;
                    end else if (switched) begin
                        s_nxt.st = ST_PRE2;
                    end else if (lock_fall) begin
                        s_nxt.st = ST_LOST;
                    end
                end
                ST_LOST, ST_PRE2: begin
                    if (lose_all) begin
                        s_nxt.st = ST_HOLD;
                    end else if (switched) begin
                        s_nxt.st = ST_PRE2;
                    end else if (lock_rise) begin
                        s_nxt.st = ST_LOCK;
                    end
                end
                ST_HOLD: begin
                    if (ref_selected && !ref_disqualified) begin
                        s_nxt.st = ST_PRE2;
                    end
                end
                default: begin
                    s_nxt.st = ST_FREE;
                end
            endcase
        end else if (s_r.cfg == MODE_FREE) begin
            s_nxt.st = ST_FREE;
        end else if (s_r.cfg == MODE_HOLD) begin
            s_nxt.st = ST_HOLD;
        end else if (s_r.cfg == MODE_LOCK) begin
            s_nxt.st = ST_LOCK;
        end else if (s_r.cfg == MODE_PRE2) begin
            s_nxt.st = ST_PRE2;
        end else if (s_r.cfg == MODE_PRE) begin
            s_nxt.st = ST_PRE;
        end else if (s_r.cfg == MODE_LOST) begin
            s_nxt.st = ST_LOST;
        end else begin
            s_nxt.st = ST_DCO;
        end

        // Flag set wins over a clear in the same cycle
        if (s_nxt.st != s_r.st) begin
            s_nxt.chg = 1'b1;
        end
        s_nxt.irq = s_nxt.chg && s_nxt.mask;

        // Stage timer restarts on every new lock attempt
        if (s_nxt.st != s_r.st || switched) begin
            s_nxt.cnt = '0;
        end else if (s_r.cnt < 28'(START_CNT)) begin
            s_nxt.cnt = s_r.cnt + 28'h1;
        end
        if (s_nxt.st == ST_LOCK) begin
            s_nxt.stg = STG_LOCKED;
        end else if (s_nxt.cnt < 28'(START_CNT)) begin
            s_nxt.stg = STG_START;
        end else begin
            s_nxt.stg = STG_ACQ;
        end
        if (s_nxt.stg == STG_LOCKED) begin
            s_nxt.bw = s_r.lck_c[BW_LSB +: 5];
            s_nxt.damp = s_r.lck_c[DAMP_LSB +: 3];
        end else if (s_nxt.stg == STG_START) begin
            s_nxt.bw = s_r.start_c[BW_LSB +: 5];
            s_nxt.damp = s_r.start_c[DAMP_LSB +: 3];
        end else begin
            s_nxt.bw = s_r.acq_c[BW_LSB +: 5];
            s_nxt.damp = s_r.acq_c[DAMP_LSB +: 3];
        end

        // Holdover keeps the last frequency seen while locked
        if (s_r.st == ST_LOCK) begin
            s_nxt.hold = ref_freq_offset;
        end
        case (s_r.st)
            ST_FREE: step_off = '0;
            ST_HOLD: step_off = s_r.hold;
            ST_DCO: step_off = s_r.freq;
            default: step_off = ref_freq_offset;
        endcase
        // Signed offset added each cycle, so phase drifts by offset times duration
        s_nxt.acc = s_r.acc + NOMINAL_STEP
            + {{(ACC_W - FREQ_W){step_off[FREQ_W-1]}}, step_off};
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '{st: ST_FREE, stg: STG_START, cfg: MODE_CFG_RST, chg: 1'b0,
                mask: 1'b0, start_c: START_RST, acq_c: ACQ_RST, lck_c: LOCKED_RST,
                flo: '0, freq: '0, hold: '0, cnt: '0, lock_q: 1'b0, acc: '0,
                ack: 1'b0, rdata: '0, irq: 1'b0, bw: START_RST[4:0],
                damp: START_RST[7:5], sw: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign lnk.ack = s_r.ack;
    assign lnk.rdata = s_r.rdata;
    assign lnk.irq = s_r.irq;
    assign loop_state = s_r.st;
    assign loop_stage = s_r.stg;
    assign active_bandwidth = s_r.bw;
    assign active_damping = s_r.damp;
    assign switch_event = s_r.sw;
    assign dco_phase = s_r.acc;
endmodule : loop_ctrl

// ---- hw/servo_host.sv ----
`timescale 1ns/100ps
module servo_host (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Link to the loop controller
    loop_link.host lnk,
    // Device interrupt seen by software
    output logic dev_irq
);
    import loop_ctrl_pkg::*;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic req;
        logic we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic irq;
    } host_t;

    host_t h_r;
    host_t h_nxt;

    always_comb begin
        h_nxt = h_r;
        h_nxt.ack = 1'b0;
        h_nxt.irq = lnk.irq;
        // Link transfer ends on the device ack; read data captured there
        if (h_r.req && lnk.ack) begin
            h_nxt.req = 1'b0;
            h_nxt.rdata = lnk.rdata;
        end
        if (cyc_i && stb_i && !h_r.ack) begin
            h_nxt.ack = 1'b1;
            h_nxt.dat = '0;
            if (adr_i == HOST_CTRL) begin
                h_nxt.dat = {23'h0, h_r.we, h_r.req, 3'h0, h_r.addr};
                // A command while busy is dropped; software polls busy first
                if (we_i && sel_i[0] && !h_r.req) begin
                    h_nxt.addr = dat_i[ADDR_W-1:0];
                    h_nxt.we = dat_i[CTRL_WE_BIT];
                    h_nxt.req = 1'b1;
                end
            end else if (adr_i == HOST_WDATA) begin
                h_nxt.dat = h_r.wdata;
                if (we_i) begin
                    for (int i = 0; i < 4; i++) begin
                        if (sel_i[i]) begin
                            h_nxt.wdata[8*i +: 8] = dat_i[8*i +: 8];
                        end
                    end
                end
            end else if (adr_i == HOST_RDATA) begin
                h_nxt.dat = h_r.rdata;
            end else if (adr_i == HOST_STAT) begin
                h_nxt.dat = {30'h0, h_r.irq, h_r.req};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            h_r <= '0;
        end else begin
            h_r <= h_nxt;
        end
    end

    assign ack_o = h_r.ack;
    assign dat_o = h_r.dat;
    assign lnk.req = h_r.req;
    assign lnk.we = h_r.we;
    assign lnk.addr = h_r.addr;
    assign lnk.wdata = h_r.wdata;
    assign dev_irq = h_r.irq;
endmodule : servo_host

// ---- test/loop_link_monitor.sv ----
`timescale 1ns/100ps
module loop_link_monitor
    import loop_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Link signals
    input wire logic req,
    input wire logic we,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic ack,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    chk_ack_after_req: assert property (ack |-> $past(req) && !$past(ack))
        else $error("ack without a pending request");
    chk_ack_one_cycle: assert property ($rose(req) |=> ack)
        else $error("ack not one cycle after request");
    chk_ack_pulse: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    chk_req_released: assert property (ack |=> !req)
        else $error("request not dropped after ack");
    chk_req_gap: assert property ($fell(req) |-> !req ##1 !req)
        else $error("requests closer than two cycles");
    chk_req_held: assert property (req && !ack |=> req && $stable({we, addr, wdata}))
        else $error("request changed while waiting");
    chk_rdata_hold: assert property ($changed(rdata) |-> ack)
        else $error("read data changed outside an answer");
    // Interrupt only clears through a mask or event write
    chk_irq_clear: assert property ($fell(irq) |->
        $past(req && we, 1) || $past(req && we, 2) || $past(req && we, 3))
        else $error("interrupt dropped without a write");

    cover property (ack && we && addr == REG_MODE_CFG && wdata[4:0] == MODE_DCO);
    cover property (ack && we && addr == REG_FREQ_HI);
    cover property ($rose(irq));
endmodule : loop_link_monitor

// ---- test/tb.sv ----
`timescale 1ns/100ps
module tb;
    import loop_ctrl_pkg::*;
    typedef struct packed {
        logic [4:0] code;
        loop_state_t st;
    } row_t;
    // Short start window keeps the stage timer test quick
    localparam int START_N = 20;
    localparam logic [47:0] NOM = 48'h1000_0000_0000;
    localparam row_t ROWS [7] = '{'{MODE_FREE, ST_FREE}, '{MODE_HOLD, ST_HOLD},
        '{MODE_LOCK, ST_LOCK}, '{MODE_PRE2, ST_PRE2}, '{MODE_PRE, ST_PRE},
        '{MODE_LOST, ST_LOST}, '{MODE_DCO, ST_DCO}};
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'hF;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] dat_o;
    logic ack_o;
    logic dev_irq;
    logic ref_sel = 1'b0;
    logic disq = 1'b0;
    logic other_q = 1'b0;
    logic rev = 1'b0;
    logic frc = 1'b0;
    logic lock_ind = 1'b0;
    logic [39:0] fofs = 40'h0;
    logic [2:0] loop_state;
    logic [1:0] loop_stage;
    logic [4:0] bw;
    logic [2:0] damp;
    logic sw_ev;
    logic [47:0] phase;
    logic [31:0] rd;
    int n_mismatch = 0;
    int comparisons = 0;

    loop_link lnk ();
    loop_ctrl #(.START_CNT(START_N), .NOMINAL_STEP(NOM)) u_loop_ctrl (.clk(clk),
        .rst_b(rst_b), .lnk(lnk), .ref_selected(ref_sel), .ref_disqualified(disq),
        .other_qualified(other_q), .revertive_pick(rev), .forced_change(frc),
        .loop_lock_indicator(lock_ind), .ref_freq_offset(fofs), .loop_state(loop_state),
        .loop_stage(loop_stage), .active_bandwidth(bw), .active_damping(damp),
        .switch_event(sw_ev), .dco_phase(phase));
    servo_host u_servo_host (.clk(clk), .rst_b(rst_b), .cyc_i(wb_cyc), .stb_i(wb_stb),
        .we_i(wb_we), .adr_i(wb_adr), .sel_i(wb_sel), .dat_i(wb_dat), .dat_o(dat_o),
        .ack_o(ack_o), .lnk(lnk), .dev_irq(dev_irq));
    loop_link_monitor u_loop_link_monitor (.clk(clk), .rst_b(rst_b), .req(lnk.req),
        .we(lnk.we), .addr(lnk.addr), .wdata(lnk.wdata), .ack(lnk.ack),
        .rdata(lnk.rdata), .irq(lnk.irq));

    initial begin
        forever #5 clk = ~clk;
    end

    task give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    task check(input string name, input logic [47:0] seen, input logic [47:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // Reads after an edge see the values sampled at that edge
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_dat <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        check("wb_ack", 48'(ack_o), 48'h1);
        rd = dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk);
    endtask : wb

    task wait_idle();
        int n;
        n = 0;
        do begin
            wb(1'b0, HOST_STAT, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 20);
    endtask : wait_idle

    task link_wr(input logic [3:0] idx, input logic [31:0] d);
        wb(1'b1, HOST_WDATA, d);
        wb(1'b1, HOST_CTRL, (32'h1 << CTRL_WE_BIT) | 32'(idx));
        wait_idle();
    endtask : link_wr

    task link_rd(input logic [3:0] idx);
        wb(1'b1, HOST_CTRL, 32'(idx));
        wait_idle();
        wb(1'b0, HOST_RDATA, 32'h0);
    endtask : link_rd

    task phase_chk(input logic [47:0] step);
        logic [47:0] p0;
        p0 = phase;
        tick(10);
        check("dco_phase", phase - p0, step * 48'd10);
    endtask : phase_chk

    initial begin
        #500_000;
        $display("[ERR] watchdog expected finish seen hang");
        n_mismatch++;
        give_verdict();
    end

    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        tick(1);
        check("loop_state", loop_state, ST_FREE);
        check("loop_stage", loop_stage, STG_START);
        check("bandwidth", bw, START_RST[4:0]);
        check("damping", damp, START_RST[7:5]);
        link_rd(REG_START);
        check("start_code", rd, START_RST);
        link_rd(REG_ACQ);
        check("acq_code", rd, ACQ_RST);
        link_rd(REG_LOCKED);
        check("locked_code", rd, LOCKED_RST);
        link_rd(REG_MASK);
        check("mask", rd, 48'h0);
        foreach (ROWS[i]) begin
            link_wr(REG_MODE_CFG, 32'(ROWS[i].code));
            tick(3);
            check("loop_state", loop_state, ROWS[i].st);
            link_rd(REG_MODE_STS);
            check("mode_status", rd, ROWS[i].code);
        end
        link_rd(REG_EVENT);
        check("event", rd, 48'h1);
        check("dev_irq", dev_irq, 1'b0);
        link_wr(REG_MODE_CFG, 32'h03);
        tick(3);
        check("loop_state", loop_state, ST_DCO);
        link_rd(4'hF);
        check("unmapped", rd, 48'h0);
        phase_chk(NOM);
        link_wr(REG_FREQ_LO, 32'hFFFF_FFFF);
        phase_chk(NOM);
        link_wr(REG_FREQ_HI, 32'hFF);
        phase_chk(NOM - 48'd1);
        link_rd(REG_FREQ_HI);
        check("freq_hi", rd, 48'hFF);
        link_wr(REG_FREQ_LO, 32'h100);
        link_wr(REG_FREQ_HI, 32'h0);
        phase_chk(NOM + 48'h100);
        link_wr(REG_MODE_CFG, 32'(MODE_AUTO));
        tick(3);
        check("loop_state", loop_state, ST_FREE);
        // A live reference offset must not reach the free-running step
        fofs <= 40'h40;
        phase_chk(NOM);
        link_wr(REG_ACQ, 32'hB2);
        link_wr(REG_LOCKED, 32'h3F);
        link_rd(REG_LOCKED);
        check("locked_code", rd, 48'h35);
        link_wr(REG_EVENT, 32'h1);
        link_wr(REG_MASK, 32'h1);
        tick(3);
        check("dev_irq", dev_irq, 1'b0);
        check("loop_state", loop_state, ST_FREE);
        ref_sel <= 1'b1;
        fofs <= 40'h40;
        tick(2);
        check("loop_state", loop_state, ST_PRE);
        tick(2);
        check("dev_irq", dev_irq, 1'b1);
        check("loop_stage", loop_stage, STG_START);
        check("bandwidth", bw, START_RST[4:0]);
        tick(30);
        check("loop_stage", loop_stage, STG_ACQ);
        check("bandwidth", bw, 48'h12);
        check("damping", damp, 48'h5);
        lock_ind <= 1'b1;
        tick(2);
        check("loop_state", loop_state, ST_LOCK);
        check("loop_stage", loop_stage, STG_LOCKED);
        check("bandwidth", bw, BW_MAX);
        check("damping", damp, 48'h1);
        phase_chk(NOM + 48'h40);
        frc <= 1'b1;
        tick(1);
        frc <= 1'b0;
        tick(1);
        check("switch_event", sw_ev, 1'b1);
        check("loop_state", loop_state, ST_PRE2);
        rev <= 1'b1;
        tick(1);
        rev <= 1'b0;
        tick(1);
        check("switch_event", sw_ev, 1'b1);
        lock_ind <= 1'b0;
        tick(1);
        lock_ind <= 1'b1;
        tick(2);
        check("loop_state", loop_state, ST_LOCK);
        lock_ind <= 1'b0;
        tick(2);
        check("loop_state", loop_state, ST_LOST);
        disq <= 1'b1;
        other_q <= 1'b1;
        tick(1);
        disq <= 1'b0;
        tick(1);
        check("switch_event", sw_ev, 1'b1);
        check("loop_state", loop_state, ST_PRE2);
        lock_ind <= 1'b1;
        tick(2);
        check("loop_state", loop_state, ST_LOCK);
        disq <= 1'b1;
        other_q <= 1'b0;
        tick(2);
        check("loop_state", loop_state, ST_HOLD);
        fofs <= 40'hFF_FFFF_FF00;
        tick(1);
        phase_chk(NOM + 48'h40);
        link_wr(REG_EVENT, 32'h1);
        tick(2);
        check("dev_irq", dev_irq, 1'b0);
        disq <= 1'b0;
        tick(2);
        check("loop_state", loop_state, ST_PRE2);
        tick(1);
        check("dev_irq", dev_irq, 1'b1);
        rst_b <= 1'b0;
        tick(2);
        rst_b <= 1'b1;
        tick(1);
        check("loop_state", loop_state, ST_FREE);
        check("bandwidth", bw, START_RST[4:0]);
        give_verdict();
    end
endmodule : tb
